// ===== src/panel_pkg.sv
// Constants, field layouts and carrier types of the panel transition block.
// Assumes a 250 MHz clk and a byte-addressed Avalon-MM register bus.
//
// Overview of operation
// - Auto press runs transition, lamp while running
// - Auto press during run aborts in place
// - Next auto press finishes the remainder
// - Auto from midway lever finishes remaining time
// - Dial with auto held long sets duration
// - Lever drives progress, end stop completes
// - Lever passing auto progress takes control
// - Mix weights always sum to full
// - Mix and wipe exclusive, lamps follow
// - Dial with wipe held long changes pattern
// - Tally lamp shows bus feeding program
// - Delegation: all off or one blinking
// - Blinking press clears, other press moves
// - Lamp lights on selected crosspoint source
// - Off delegation: rows feed program/preset by mode
// - Buttons give slots 1-5, shifted 6-10
// - Aux: B slots, A fixed outputs
// - Picture-in-picture takes B row only
// - Key: B fill, A key source
// - Inputs 1-2 normal/pixel, 3-4 all modes
// - Mismatched input format shows black, except SD input to HD system in pixel/upconv mode
// - High-res multiview blocks multiview outputs
package panel_pkg;
	localparam int CLK_NS = 4;
	localparam int LONG_HOLD_MS = 1000;
	localparam int BLINK_HALF_MS = 500;
	localparam int TICK_NS = 1000;
	localparam int HOLD_CYC = LONG_HOLD_MS * 1000000 / CLK_NS;
	localparam int BLINK_CYC = BLINK_HALF_MS * 1000000 / CLK_NS;
	localparam int TICK_CYC = TICK_NS / CLK_NS;
	localparam logic [7:0] PROG_FULL = 8'hff;
	localparam logic [15:0] DUR_RST = 16'h0f52;
	localparam logic [15:0] DUR_STEP = 16'h0064;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_DUR = 8'h04;
	localparam logic [7:0] REG_WIPE = 8'h08;
	localparam logic [7:0] REG_IN_MODE = 8'h0c;
	localparam logic [7:0] REG_OUT = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] REG_SOURCES = 8'h18;
	localparam logic [1:0] BUS_AB = 2'h0;
	localparam logic [1:0] BUS_PGM_A = 2'h1;
	localparam logic [1:0] BUS_PGM_B = 2'h2;
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_PIXEL = 2'h1;
	localparam logic [1:0] MODE_UPCONV = 2'h2;
	localparam logic [2:0] OUT_PGM = 3'h0;
	localparam logic [2:0] OUT_MV = 3'h4;
	localparam logic [2:0] OUT_LAST = 3'h5;
	localparam logic [3:0] SRC_RST = 4'h1;
	localparam logic [3:0] SRC_OUT_OFS = 4'ha;
	localparam logic [3:0] SHIFT_OFS = 4'h5;
	typedef enum logic [1:0] {DLG_OFF, DLG_AUX, DLG_PIP, DLG_KEY} deleg_type;
	typedef struct packed {
		logic auto_transition_button;
		logic mix;
		logic wipe;
		logic shift;
		logic [2:0] deleg;
		logic [4:0] xpt_a;
		logic [4:0] xpt_b;
		logic dial_up;
		logic dial_down;
	} buttons_type;
	typedef struct packed {
		logic [3:0] program_bus;
		logic [3:0] preset_bus;
		logic [3:0] aux;
		logic [3:0] picture_in_picture;
		logic [3:0] key_fill;
		logic [3:0] key_source;
	} sources_type;
	typedef struct packed {
		logic system_hd;
		logic hires_mv;
		logic [1:0] bus_mode;
	} ctrl_type;
	typedef struct packed {
		logic [7:0] progress;
		logic running;
		logic wipe_sel;
		logic [1:0] deleg;
		logic program_on_b;
		logic [3:0] black;
	} status_type;
endpackage : panel_pkg

// ===== src/switcher_panel_transition_select.sv
// Panel logic: background transition engine, mix/wipe select, bus delegation,
// crosspoint mapping and input/output checks, with an Avalon-MM slave.
// Assumes panel pins are asynchronous and format flags come from the clk domain.
`timescale 1ns/1ps
`default_nettype none
module switcher_panel_transition_select #(
	parameter int HOLD_CYCLES = panel_pkg::HOLD_CYC,
	parameter int BLINK_CYCLES = panel_pkg::BLINK_CYC
) (
	input wire logic clk, // 250 MHz clock
	input wire logic nrst, // synchronous reset
	input wire panel_pkg::buttons_type buttons, // panel buttons, high = pressed
	input wire logic [7:0] lever_pos, // lever position
	input wire logic [3:0] in_hd, // input carries HD
	input wire logic [3:0] in_rate_ok, // input vertical rate matches system
	input wire logic [7:0] address, // byte address
	input wire logic read, // read request
	input wire logic write, // write request
	input wire logic [31:0] writedata, // write data
	output logic [31:0] readdata, // read data
	output logic waitrequest, // slave stall
	output logic auto_lamp, // auto button lamp
	output logic mix_lamp, // mix lamp
	output logic wipe_lamp, // wipe lamp
	output logic tally_a, // A bus feeds program
	output logic tally_b, // B bus feeds program
	output logic [2:0] deleg_lamp, // aux, pip, key lamps
	output logic [4:0] xpt_lamp_a, // A row lamps
	output logic [4:0] xpt_lamp_b, // B row lamps
	output logic [7:0] progress, // transition progress
	output logic [7:0] weight_pgm, // program bus weight
	output logic [7:0] weight_pst, // preset bus weight
	output panel_pkg::sources_type sources, // selected sources
	output logic [3:0] wipe_pattern, // wipe pattern
	output logic [3:0] input_black, // input replaced by black
	output logic [5:0] out_sel // two 3-bit output assignments
);
	import panel_pkg::*;

	function automatic logic [3:0] first_slot(input logic [4:0] v, input logic sh);
		logic [3:0] s;
		s = 4'h0;
		for (int i = 4; i >= 0; i--) begin
			if (v[i]) begin
				s = 4'(i + 1);
			end
		end
		return (sh && s != 4'h0) ? s + SHIFT_OFS : s;
	endfunction : first_slot

	function automatic logic [4:0] lamp_row(input logic [3:0] src, input logic [3:0] base);
		logic [4:0] r;
		r = 5'h0;
		for (int i = 0; i < 5; i++) begin
			r[i] = (src == base + 4'(i + 1));
		end
		return r;
	endfunction : lamp_row

	////////////////////////////////////////////////////////////////////////////
	localparam int NB = $bits(buttons_type);
	localparam int HW = $clog2(HOLD_CYCLES + 1);
	logic [NB+7:0] s1_q, s2_q, s3_q, f_q, prev_q;
	wire [NB+7:0] agree = ~(s2_q ^ s3_q);
	buttons_type btn, press;
	logic [7:0] lever_s, lever_prev_q;
	assign btn = buttons_type'(f_q[NB+7:8]);
	assign press = buttons_type'(f_q[NB+7:8] & ~prev_q[NB+7:8]);
	assign lever_s = f_q[7:0];

	always_ff @(posedge clk) begin
		if (!nrst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			f_q <= '0;
			prev_q <= '0;
			lever_prev_q <= 8'h00;
		end else begin
			s1_q <= {buttons, lever_pos};
			s2_q <= s1_q;
			s3_q <= s2_q;
			f_q <= (agree & s3_q) | (~agree & f_q);
			prev_q <= f_q;
			lever_prev_q <= lever_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Long-hold detection for the auto and wipe buttons.
	logic [HW-1:0] hold_q [2];
	logic [1:0] held_long;
	wire [1:0] hold_btn = {btn.wipe, btn.auto_transition_button};
	generate
		for (genvar g = 0; g < 2; g++) begin : g_hold
			assign held_long[g] = hold_q[g] == HW'(HOLD_CYCLES);
			always_ff @(posedge clk) begin
				if (!nrst || !hold_btn[g]) begin
					hold_q[g] <= '0;
				end else if (!held_long[g]) begin
					hold_q[g] <= hold_q[g] + 1'b1;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Register state.
	ctrl_type ctrl_q;
	logic [15:0] dur_q;
	logic [3:0] wipe_q;
	logic [7:0] in_mode_q;
	logic [5:0] out_q;
	logic wait_q;
	wire req = read | write;
	wire wr_en = write && !wait_q;
	wire dial_auto = held_long[0] && btn.auto_transition_button;
	wire dial_wipe = held_long[1] && btn.wipe;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			wait_q <= 1'b1;
		end else begin
			wait_q <= !(req && wait_q);
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			ctrl_q <= '{system_hd: 1'b1, hires_mv: 1'b0, bus_mode: BUS_PGM_A};
			dur_q <= DUR_RST;
			wipe_q <= 4'h0;
		end else begin
			if (wr_en && address == REG_CTRL) begin
				ctrl_q <= ctrl_type'(writedata[$bits(ctrl_type)-1:0]);
			end
			if (wr_en && address == REG_DUR) begin
				dur_q <= writedata[15:0];
			end else if (dial_auto && press.dial_up && dur_q <= ~DUR_STEP) begin
				dur_q <= dur_q + DUR_STEP;
			end else if (dial_auto && press.dial_down && dur_q > DUR_STEP) begin
				dur_q <= dur_q - DUR_STEP;
			end
			if (wr_en && address == REG_WIPE) begin
				wipe_q <= writedata[3:0];
			end else if (dial_wipe && press.dial_up) begin
				wipe_q <= wipe_q + 4'h1;
			end else if (dial_wipe && press.dial_down) begin
				wipe_q <= wipe_q - 4'h1;
			end
		end
	end

	// Input modes and output assignments accept each field on its own, so a
	// partly illegal write still updates the legal fields.
	generate
		for (genvar g = 0; g < 4; g++) begin : g_in
			wire [1:0] nm = writedata[2*g+1:2*g];
			wire ok = (g >= 2) || nm == MODE_NORMAL || nm == MODE_PIXEL;
			wire [1:0] md = in_mode_q[2*g+1:2*g];
			wire exc = ctrl_q.system_hd && !in_hd[g] && in_rate_ok[g]
				&& (md == MODE_PIXEL || md == MODE_UPCONV);
			wire bad = (in_hd[g] != ctrl_q.system_hd || !in_rate_ok[g]) && !exc;
			always_ff @(posedge clk) begin
				if (!nrst) begin
					in_mode_q[2*g+1:2*g] <= MODE_NORMAL;
					input_black[g] <= 1'b0;
				end else begin
					if (wr_en && address == REG_IN_MODE && ok) begin
						in_mode_q[2*g+1:2*g] <= nm;
					end
					input_black[g] <= bad;
				end
			end
		end
		for (genvar g = 0; g < 2; g++) begin : g_out
			wire [2:0] no = writedata[3*g+2:3*g];
			wire ok = no <= OUT_LAST && !(ctrl_q.hires_mv && no == OUT_MV);
			always_ff @(posedge clk) begin
				if (!nrst) begin
					out_q[3*g+2:3*g] <= OUT_PGM;
				end else if (wr_en && address == REG_OUT && ok) begin
					out_q[3*g+2:3*g] <= no;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Transition engine. The 1 us tick keeps the step counter narrow.
	logic [7:0] tick_q;
	logic [15:0] step_q;
	logic [7:0] prog_q, prog_d;
	logic run_q, run_d, manual_q, manual_d, dir_q, pgm_b_q, done, by_lever;
	wire tick = tick_q == 8'(TICK_CYC - 1);
	wire step_en = run_q && tick && step_q >= dur_q - 16'h1;
	wire [7:0] lever_rel = dir_q ? ~lever_s : lever_s;
	wire lever_moved = lever_s != lever_prev_q;

	always_comb begin
		run_d = run_q;
		prog_d = prog_q;
		manual_d = manual_q;
		by_lever = 1'b0;
		done = 1'b0;
		if (press.auto_transition_button) begin
			run_d = !run_q;
			manual_d = 1'b0;
		end else if (lever_moved && (manual_q || lever_rel > prog_q)) begin
			run_d = 1'b0;
			prog_d = lever_rel;
			manual_d = 1'b1;
			by_lever = 1'b1;
		end else if (step_en) begin
			prog_d = prog_q + 8'h1;
		end
		if (prog_d == PROG_FULL) begin
			done = 1'b1;
			prog_d = 8'h00;
			run_d = 1'b0;
			manual_d = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst || tick) begin
			tick_q <= 8'h00;
		end else begin
			tick_q <= tick_q + 8'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst || !run_q || step_en) begin
			step_q <= 16'h0;
		end else if (tick) begin
			step_q <= step_q + 16'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			prog_q <= 8'h00;
			run_q <= 1'b0;
			manual_q <= 1'b0;
			dir_q <= 1'b0;
		end else begin
			prog_q <= prog_d;
			run_q <= run_d;
			manual_q <= manual_d;
			dir_q <= dir_q ^ (done && by_lever);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Delegation and source selection.
	deleg_type dlg_q, dlg_hit, dlg_d;
	logic blink_q, wipe_sel_q;
	localparam int BW = $clog2(BLINK_CYCLES + 1);
	logic [BW-1:0] blink_cnt_q;
	logic [3:0] src_a_q, src_b_q, aux_q, pip_q, kf_q, ks_q;
	wire [3:0] slot_a = first_slot(press.xpt_a, btn.shift);
	wire [3:0] slot_b = first_slot(press.xpt_b, btn.shift);
	wire [3:0] out_a = first_slot(press.xpt_a, 1'b0) + SRC_OUT_OFS;
	wire hit_a = |press.xpt_a;
	wire hit_b = |press.xpt_b;
	wire swap = done && ctrl_q.bus_mode != BUS_AB;
	assign dlg_hit = press.deleg[0] ? DLG_AUX : press.deleg[1] ? DLG_PIP : DLG_KEY;
	assign dlg_d = ~|press.deleg ? dlg_q : dlg_hit == dlg_q ? DLG_OFF : dlg_hit;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			dlg_q <= DLG_OFF;
			wipe_sel_q <= 1'b0;
			blink_cnt_q <= '0;
			blink_q <= 1'b0;
		end else begin
			dlg_q <= dlg_d;
			if (press.mix) begin
				wipe_sel_q <= 1'b0;
			end else if (press.wipe) begin
				wipe_sel_q <= 1'b1;
			end
			if (blink_cnt_q == BW'(BLINK_CYCLES - 1)) begin
				blink_cnt_q <= '0;
				blink_q <= !blink_q;
			end else begin
				blink_cnt_q <= blink_cnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			{src_a_q, src_b_q, aux_q, pip_q, kf_q, ks_q} <= {6{SRC_RST}};
			pgm_b_q <= 1'b0;
		end else begin
			pgm_b_q <= ctrl_q.bus_mode == BUS_AB ? pgm_b_q ^ done
				: ctrl_q.bus_mode == BUS_PGM_B;
			if (swap) begin
				src_a_q <= src_b_q;
				src_b_q <= src_a_q;
			end
			case (dlg_q)
				DLG_OFF: begin
					if (hit_a && !swap) begin
						src_a_q <= slot_a;
					end
					if (hit_b && !swap) begin
						src_b_q <= slot_b;
					end
				end
				DLG_AUX: begin
					if (hit_b) begin
						aux_q <= slot_b;
					end else if (hit_a) begin
						aux_q <= out_a;
					end
				end
				DLG_PIP: begin
					if (hit_b) begin
						pip_q <= slot_b;
					end
				end
				DLG_KEY: begin
					if (hit_b) begin
						kf_q <= slot_b;
					end
					if (hit_a) begin
						ks_q <= slot_a;
					end
				end
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registered panel and datapath outputs.
	logic [4:0] lamp_a_d, lamp_b_d;
	wire [3:0] shb = btn.shift ? SHIFT_OFS : 4'h0;
	always_comb begin
		lamp_a_d = 5'h0;
		lamp_b_d = 5'h0;
		case (dlg_q)
			DLG_OFF: begin
				lamp_a_d = lamp_row(src_a_q, shb);
				lamp_b_d = lamp_row(src_b_q, shb);
			end
			DLG_AUX: begin
				lamp_a_d = lamp_row(aux_q, SRC_OUT_OFS);
				lamp_b_d = lamp_row(aux_q, shb);
			end
			DLG_PIP: lamp_b_d = lamp_row(pip_q, shb);
			DLG_KEY: begin
				lamp_a_d = lamp_row(ks_q, shb);
				lamp_b_d = lamp_row(kf_q, shb);
			end
			default: begin
			end
		endcase
	end

	status_type stat;
	logic [31:0] rd_d;
	assign stat = '{progress: prog_q, running: run_q, wipe_sel: wipe_sel_q,
		deleg: dlg_q, program_on_b: pgm_b_q, black: input_black};
	always_comb begin
		case (address)
			REG_CTRL: rd_d = 32'(ctrl_q);
			REG_DUR: rd_d = 32'(dur_q);
			REG_WIPE: rd_d = 32'(wipe_q);
			REG_IN_MODE: rd_d = 32'(in_mode_q);
			REG_OUT: rd_d = 32'(out_q);
			REG_STATUS: rd_d = 32'(stat);
			REG_SOURCES: rd_d = 32'(sources);
			default: rd_d = 32'h0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			readdata <= 32'h0;
			{auto_lamp, mix_lamp, wipe_lamp, tally_a, tally_b} <= 5'h0a;
			{deleg_lamp, xpt_lamp_a, xpt_lamp_b} <= 13'h0;
			{progress, weight_pst} <= 16'h0;
			weight_pgm <= PROG_FULL;
			sources <= {6{SRC_RST}};
			wipe_pattern <= 4'h0;
			out_sel <= {2{OUT_PGM}};
		end else begin
			if (req && wait_q) begin
				readdata <= rd_d;
			end
			auto_lamp <= run_q;
			mix_lamp <= !wipe_sel_q;
			wipe_lamp <= wipe_sel_q;
			tally_a <= !pgm_b_q;
			tally_b <= pgm_b_q;
			deleg_lamp[0] <= blink_q && dlg_q == DLG_AUX;
			deleg_lamp[1] <= blink_q && dlg_q == DLG_PIP;
			deleg_lamp[2] <= blink_q && dlg_q == DLG_KEY;
			xpt_lamp_a <= lamp_a_d;
			xpt_lamp_b <= lamp_b_d;
			progress <= prog_q;
			weight_pgm <= PROG_FULL - prog_q;
			weight_pst <= prog_q;
			sources <= '{program_bus: pgm_b_q ? src_b_q : src_a_q,
				preset_bus: pgm_b_q ? src_a_q : src_b_q, aux: aux_q,
				picture_in_picture: pip_q, key_fill: kf_q, key_source: ks_q};
			wipe_pattern <= wipe_q;
			out_sel <= out_q;
		end
	end
	assign waitrequest = wait_q;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	property p_auto_start;
		!run_q && press.auto_transition_button |=> run_q ##1 auto_lamp;
	endproperty
	a_auto_start: assert property (p_auto_start) else $error("auto lamp not lit");
	property p_abort;
		run_q && press.auto_transition_button |=> !run_q && $stable(prog_q);
	endproperty
	a_abort: assert property (p_abort) else $error("abort did not hold progress");
	property p_weights;
		weight_pgm + weight_pst == 9'(PROG_FULL);
	endproperty
	a_weights: assert property (p_weights) else $error("mix weights off");
	property p_excl;
		mix_lamp != wipe_lamp;
	endproperty
	a_excl: assert property (p_excl) else $error("mix and wipe lamps agree");
	property p_tally;
		tally_a != tally_b;
	endproperty
	a_tally: assert property (p_tally) else $error("tally lamps agree");
	property p_deleg;
		$onehot0(deleg_lamp);
	endproperty
	a_deleg: assert property (p_deleg) else $error("two delegation lamps");
	property p_clear;
		dlg_q != DLG_OFF && press.deleg == (3'h1 << (dlg_q - 1)) |=> dlg_q == DLG_OFF;
	endproperty
	a_clear: assert property (p_clear) else $error("blinking press kept");
	property p_modes;
		in_mode_q[1] == 1'b0 && in_mode_q[3] == 1'b0;
	endproperty
	a_modes: assert property (p_modes) else $error("illegal mode on input 1 or 2");
	property p_mv;
		ctrl_q.hires_mv && $changed(out_q) |->
			($stable(out_q[2:0]) || out_q[2:0] != OUT_MV)
			&& ($stable(out_q[5:3]) || out_q[5:3] != OUT_MV);
	endproperty
	a_mv: assert property (p_mv) else $error("multiview assigned");
	property p_wait;
		req && wait_q |=> !waitrequest ##1 waitrequest;
	endproperty
	a_wait: assert property (p_wait) else $error("bus answer not one cycle");

	c_auto_done: cover property (run_q && done);
	c_abort: cover property (run_q ##1 press.auto_transition_button);
	c_handover: cover property (run_q && by_lever);
	c_aux_out: cover property (dlg_q == DLG_AUX && hit_a);
endmodule : switcher_panel_transition_select
`default_nettype wire

// ===== verification/panel_operator.sv
// Operator model: presses panel buttons, turns the dial and moves the lever.
// Assumes its tasks are called right after a rising clk edge.
`timescale 1ns/1ps
`default_nettype none
module panel_operator (
	input wire logic clk, // panel clock
	output panel_pkg::buttons_type buttons, // button levels
	output logic [7:0] lever_pos // lever position
);
	import panel_pkg::*;
	initial begin
		buttons <= '0;
		lever_pos <= 8'h00;
	end
	////////////////////////////////////////////////////////////
	// Presses are held well past the synchroniser and filter.
	task automatic press(input int b, input logic sh);
		buttons[15] <= sh;
		repeat (2) @(posedge clk);
		buttons[b] <= 1'b1;
		repeat (12) @(posedge clk);
		buttons[b] <= 1'b0;
		repeat (2) @(posedge clk);
		buttons[15] <= 1'b0;
		repeat (10) @(posedge clk);
	endtask : press
	// One dial detent while a button stays held past the long hold.
	task automatic hold_dial(input int b);
		buttons[b] <= 1'b1;
		repeat (40) @(posedge clk);
		buttons[1] <= 1'b1;
		repeat (4) @(posedge clk);
		buttons[1] <= 1'b0;
		repeat (8) @(posedge clk);
		buttons[b] <= 1'b0;
		repeat (10) @(posedge clk);
	endtask : hold_dial
	// The lever moves one step at a time so its bits never skew.
	task automatic lever(input logic [7:0] t);
		while (lever_pos != t) begin
			lever_pos <= (lever_pos < t) ? lever_pos + 8'h01 : lever_pos - 8'h01;
			repeat (2) @(posedge clk);
		end
	endtask : lever
endmodule : panel_operator
`default_nettype wire

// ===== verification/switcher_panel_transition_select_test.sv
// Self-checking bench of the panel transition block.
// Assumes one 250 MHz clock and the operator model driving the panel.
`timescale 1ns/1ps
`default_nettype none
module switcher_panel_transition_select_test;
	import panel_pkg::*;
	typedef struct packed {logic [4:0] b; logic sh; logic [7:0] src;} row_type;
	logic clk, nrst, read, write, waitrequest, auto_lamp, mix_lamp, wipe_lamp;
	logic tally_a, tally_b;
	logic [3:0] in_hd, in_rate_ok, wipe_pattern, input_black;
	logic [7:0] address, lever_pos, progress, weight_pgm, weight_pst, p;
	logic [31:0] writedata, readdata, rdata;
	logic [5:0] out_sel;
	logic [4:0] xpt_lamp_a, xpt_lamp_b;
	logic [2:0] deleg_lamp;
	buttons_type buttons;
	sources_type sources;
	int bad_count, checked, n;
	row_type rows [6] = '{'{5'd2, 1'b0, 8'h11}, '{5'd6, 1'b0, 8'h15}, '{5'd2, 1'b1, 8'h16},
		'{5'd6, 1'b1, 8'h1a}, '{5'd8, 1'b1, 8'h7a}, '{5'd4, 1'b0, 8'h73}};
	panel_operator op (.clk, .buttons, .lever_pos);
	switcher_panel_transition_select #(.HOLD_CYCLES(16), .BLINK_CYCLES(8)) DUT (
		.clk, .nrst, .buttons, .lever_pos, .in_hd, .in_rate_ok, .address, .read,
		.write, .writedata, .readdata, .waitrequest, .auto_lamp, .mix_lamp,
		.wipe_lamp, .tally_a, .tally_b, .deleg_lamp, .xpt_lamp_a, .xpt_lamp_b,
		.progress, .weight_pgm, .weight_pst, .sources, .wipe_pattern, .input_black,
		.out_sel);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	////////////////////////////////////////////////////////////
	task automatic chk(input string s, input logic [31:0] v, input logic [31:0] e);
		checked++;
		if (v !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", s, e, v);
		end
	endtask : chk
	task automatic end_sim();
		if (bad_count == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_sim
	task automatic tmo();
		bad_count++;
		end_sim();
	endtask : tmo
	// Request stays up until the edge that sees waitrequest low.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		read <= !w;
		write <= w;
		address <= a;
		writedata <= d;
		for (k = 0; k < 20; k++) begin
			@(posedge clk);
			if (waitrequest === 1'b0)
				break;
		end
		if (k == 20)
			tmo();
		rdata = readdata;
		read <= 1'b0;
		write <= 1'b0;
		// Registered outputs follow a written field one edge after the ack.
		repeat (2) @(posedge clk);
	endtask : bus
	task automatic dg(input int b, input logic [1:0] e);
		logic [2:0] acc;
		op.press(b, 1'b0);
		bus(1'b0, REG_STATUS, 32'h0);
		chk("deleg", rdata[6:5], e);
		acc = 3'h0;
		repeat (16) begin
			@(posedge clk);
			acc = acc | deleg_lamp;
		end
		chk("deleg_lamp", acc, e == 2'd0 ? 3'h0 : 3'h1 << (e - 2'd1));
	endtask : dg
	////////////////////////////////////////////////////////////
	initial begin
		nrst <= 1'b0;
		read <= 1'b0;
		write <= 1'b0;
		address <= 8'h00;
		writedata <= 32'h0;
		in_hd <= 4'hf;
		in_rate_ok <= 4'hf;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		chk("mix_wipe", {mix_lamp, wipe_lamp}, 2'b10);
		chk("tally", {tally_a, tally_b}, 2'b10);
		chk("weight", weight_pgm, 8'hff);
		chk("sources", sources, {6{4'h1}});
		bus(1'b0, REG_DUR, 32'h0);
		chk("dur", rdata, 32'h0f52);
		bus(1'b0, 8'h20, 32'h0);
		chk("unmapped", rdata, 32'h0);
		foreach (rows[i]) begin
			op.press(rows[i].b, rows[i].sh);
			chk("pgm_pst", {sources.program_bus, sources.preset_bus}, rows[i].src);
		end
		chk("xpt_lamp", xpt_lamp_b[2], 1'b1);
		op.press(16, 1'b0);
		chk("mix_wipe", {mix_lamp, wipe_lamp}, 2'b01);
		op.press(17, 1'b0);
		chk("mix_wipe", {mix_lamp, wipe_lamp}, 2'b10);
		op.hold_dial(16);
		chk("pattern", wipe_pattern, 4'h1);
		dg(12, 2'd1);
		op.press(8, 1'b0);
		chk("aux", sources.aux, 4'hc);
		chk("aux_lamp", xpt_lamp_a, 5'h02);
		dg(13, 2'd2);
		op.press(7, 1'b0);
		chk("pip_a", {sources.program_bus, sources.picture_in_picture}, 8'h71);
		op.press(3, 1'b0);
		chk("pip_b", sources.picture_in_picture, 4'h2);
		dg(14, 2'd3);
		op.press(9, 1'b1);
		chk("key_src", sources.key_source, 4'h8);
		op.press(5, 1'b0);
		chk("key_fill", sources.key_fill, 4'h4);
		dg(14, 2'd0);
		bus(1'b1, REG_IN_MODE, 32'hc6);
		bus(1'b0, REG_IN_MODE, 32'h0);
		chk("in_mode", rdata, 32'hc4);
		in_hd <= 4'h5;
		repeat (4) @(posedge clk);
		chk("black", input_black, 4'h8);
		in_hd <= 4'hf;
		bus(1'b1, REG_CTRL, 32'hd);
		bus(1'b1, REG_OUT, 32'hf);
		chk("out_range", out_sel, 6'h08);
		bus(1'b1, REG_OUT, 32'h2c);
		chk("out_mv", out_sel, 6'h28);
		bus(1'b1, REG_CTRL, 32'h9);
		bus(1'b1, REG_DUR, 32'h1);
		op.press(18, 1'b0);
		chk("auto_on", auto_lamp, 1'b1);
		for (n = 0; n < 30000 && progress < 8'h40; n++) begin
			@(posedge clk);
			chk("wsum", weight_pgm + weight_pst, 32'hff);
		end
		if (n == 30000)
			tmo();
		op.press(18, 1'b0);
		p = progress;
		chk("abort", auto_lamp, 1'b0);
		repeat (600) @(posedge clk);
		chk("held", progress, p);
		op.press(18, 1'b0);
		for (n = 0; n < 90000 && auto_lamp !== 1'b0; n++)
			@(posedge clk);
		if (n == 90000)
			tmo();
		chk("remainder", n < (256 - p) * 250, 1'b1);
		chk("done", {progress, sources.program_bus, sources.preset_bus}, 16'h0037);
		op.lever(8'h80);
		repeat (10) @(posedge clk);
		chk("lever", progress, 8'h80);
		op.lever(8'hff);
		repeat (10) @(posedge clk);
		chk("lever_end", {progress, sources.program_bus}, 12'h007);
		op.hold_dial(18);
		bus(1'b0, REG_DUR, 32'h0);
		chk("dial_dur", rdata, 32'h65);
		op.lever(8'h20);
		repeat (10) @(posedge clk);
		chk("handover", {auto_lamp, progress}, 9'h0df);
		bus(1'b1, REG_DUR, 32'h1);
		bus(1'b1, REG_CTRL, 32'h8);
		op.press(18, 1'b0);
		for (n = 0; n < 20000 && auto_lamp !== 1'b0; n++)
			@(posedge clk);
		if (n == 20000)
			tmo();
		chk("midway", n < (256 - 8'hdf) * 250, 1'b1);
		chk("ab_mode", {tally_a, tally_b, sources[23:16]}, 10'h137);
		op.press(18, 1'b0);
		nrst <= 1'b0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
		chk("rst_lamp", {auto_lamp, tally_a, waitrequest, progress}, 11'h300);
		chk("rst_src", sources, {6{4'h1}});
		end_sim();
	end
endmodule : switcher_panel_transition_select_test
`default_nettype wire
